//--- verilog/scb_pkg.sv
`default_nettype none
package scb_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned SCL_HZ = 100_000;
  // quarter of one serial bit, in clk cycles
  localparam int unsigned QTR_CYC = CLK_HZ / (4 * SCL_HZ);
  localparam int unsigned SETTLE_CYC = 4;
  localparam int unsigned CFG_BYTES = 8;

  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_IRQ_STS = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0C;
  localparam logic [7:0] OFS_CFG = 8'h10;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam int IRQ_OK = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_SRST = 2;
  localparam int CTRL_GO = 0;

  // four strap levels: 0, R, F, 1
  localparam logic [1:0] LVL_0 = 2'h0;
  localparam logic [1:0] LVL_R = 2'h1;
  localparam logic [1:0] LVL_F = 2'h2;
  localparam logic [1:0] LVL_1 = 2'h3;

  localparam logic [6:0] EEPROM_DEV = 7'h50;
  localparam logic [7:0] EEPROM_START = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // idle pin levels: read enable, clock and data lines high
  localparam logic [9:0] PINS_RST = 10'h00B;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_BIT = 2'b10,
    ST_STOP = 2'b11
  } scb_st_t;

  typedef struct packed {
    logic awvalid; logic [7:0] awaddr; logic wvalid; logic [31:0] wdata;
    logic [3:0] wstrb; logic bready; logic arvalid; logic [7:0] araddr;
    logic rready;
  } scb_axi_req_t;

  typedef struct packed {
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } scb_axi_rsp_t;

  typedef struct packed {
    logic [1:0] address_strap_low; logic [1:0] address_strap_high;
    logic [1:0] bus_role_strap; logic read_en_n; logic cal_clk;
    logic serial_bus_clock; logic sda;
  } scb_pins_t;

  typedef struct packed {
    logic serial_bus_clock_o; logic serial_bus_clock_oe; logic sda_o; logic sda_oe;
    logic load_done_n_o; logic load_done_n_oe; logic cal_clk_out;
  } scb_pout_t;
endpackage : scb_pkg
`default_nettype wire

//--- verilog/scb_pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module scb_pin_sync #(
  parameter int W = 10,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1; logic [W-1:0] s2; logic [W-1:0] s3; logic [W-1:0] q;
  } scb_sync_t;
  scb_sync_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.s1 = d;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    // a bit changes only once stages two and three agree
    s_d.q = (~(s_q.s2 ^ s_q.s3) & s_q.s3) | ((s_q.s2 ^ s_q.s3) & s_q.q);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.q;
endmodule : scb_pin_sync
`default_nettype wire

//--- verilog/scb_ctrl.sv
// Contract
// RL1: two four-level address straps give sixteen distinct slave addresses.
// RL2: straps sampled once after power-up; later changes ignored.
// RL3: role strap float selects master, high selects slave; low levels reserved.
// RL4: master mode: read enable going low starts the EEPROM load.
// RL5: master mode: done output high until load completes successfully, then low.
// RL6: master mode: read enable held low after done starts no further load.
// RL7: slave mode: read enable low holds bus engine and config registers reset.
// RL8: slave mode: host keeps read enable high or floating; weak pull-up.
// RL9: slave mode: done output undriven until read enable first low, then low.
// RL10: chained slaves: done output feeds next read enable, passing reset on.
// RL11: buffered copy of calibration clock driven out for daisy chains.
// RL12: calibration clock optional, pulled low when floating; 25 MHz when used.
// RL13: serial bus clock is open drain; received, driven low only as master.
// RL14: master load uses bus reads; each received byte lands in config registers.
`timescale 1ns/1ns
`default_nettype none
module scb_ctrl
  import scb_pkg::*;
#(
  parameter int N_CFG = CFG_BYTES,
  parameter int unsigned QTR = QTR_CYC,
  parameter logic [2:0] ADDR_TOP = 3'h2 // arbitrary upper address bits
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire scb_axi_req_t axi_i,
  output scb_axi_rsp_t axi_o,
  input wire scb_pins_t pins_i,
  output scb_pout_t pins_o,
  output logic [6:0] slave_addr,
  output logic irq
);
  typedef struct packed {
    scb_st_t st; logic [1:0] ph; logic [15:0] qc; logic [3:0] bi; logic [7:0] sh;
    logic [7:0] step; logic rd; logic last; logic nak;
    logic ok; logic fail; logic seen;
    logic [2:0] settle; logic capt; logic [3:0] saddr; logic [1:0] role; logic ren_q;
    logic [N_CFG-1:0][7:0] cfg; logic [2:0] sts; logic [2:0] mask;
    logic aw_full; logic [7:0] awa; logic w_full; logic [31:0] wd; logic [3:0] ws;
    scb_axi_rsp_t rsp; scb_pout_t pout; logic [6:0] addr; logic irq;
  } scb_state_t;

  scb_state_t s_q, s_d;
  scb_pins_t p;
  logic [9:0] p_raw;

  // pins come from outside the clk domain, calibration clock included
  scb_pin_sync #(.W(10), .RST_VAL(PINS_RST)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(pins_i),
    .q(p_raw)
  );
  assign p = scb_pins_t'(p_raw);

  logic master, slave, ren_low, ren_fall, tick, go, stretch;
  logic [2:0] ev, clr;
  logic [7:0] off, ci;
  logic [31:0] rdv;
  logic rerr;

  always_comb begin
    s_d = s_q;
    ev = 3'h0;
    clr = 3'h0;
    go = 1'b0;
    rdv = 32'h0;
    rerr = 1'b0;
    off = 8'h0;
    ci = s_q.step - 8'h03;
    master = s_q.capt && (s_q.role == LVL_F); // [RL3]
    slave = s_q.capt && (s_q.role == LVL_1); // [RL3]
    ren_low = !p.read_en_n;
    ren_fall = s_q.ren_q && !p.read_en_n;
    s_d.ren_q = p.read_en_n;

    // straps read once, after the synchroniser has settled
    if (!s_q.capt) begin
      // the synchroniser holds its reset value for three more edges after release
      if (s_q.settle == 3'(SETTLE_CYC + 2)) begin
        s_d.capt = 1'b1; // [RL2]
        s_d.saddr = {p.address_strap_high, p.address_strap_low}; // [RL1]
        s_d.role = p.bus_role_strap;
      end else begin
        s_d.settle = s_q.settle + 3'h1;
      end
    end
    s_d.addr = {ADDR_TOP, s_d.saddr};

    // register write, once address and data have both arrived
    if (s_q.rsp.bvalid && axi_i.bready) begin
      s_d.rsp.bvalid = 1'b0;
    end
    if (s_q.rsp.awready && axi_i.awvalid) begin
      s_d.aw_full = 1'b1;
      s_d.awa = axi_i.awaddr;
    end
    if (s_q.rsp.wready && axi_i.wvalid) begin
      s_d.w_full = 1'b1;
      s_d.wd = axi_i.wdata;
      s_d.ws = axi_i.wstrb;
    end
    if (s_q.aw_full && s_q.w_full && !s_q.rsp.bvalid) begin
      s_d.aw_full = 1'b0;
      s_d.w_full = 1'b0;
      s_d.rsp.bvalid = 1'b1;
      s_d.rsp.bresp = RESP_OKAY;
      off = s_q.awa - OFS_CFG;
      if (s_q.awa[7:2] == OFS_IRQ_MASK[7:2]) begin
        if (s_q.ws[0]) s_d.mask = s_q.wd[2:0];
      end else if (s_q.awa[7:2] == OFS_CTRL[7:2]) begin
        go = s_q.ws[0] && s_q.wd[CTRL_GO];
      end else if (s_q.awa[7:2] != OFS_STATUS[7:2] && s_q.awa[7:2] != OFS_IRQ_STS[7:2]
                   && !(s_q.awa >= OFS_CFG && off[7:2] < 6'(N_CFG))) begin
        s_d.rsp.bresp = RESP_SLVERR;
      end
    end
    s_d.rsp.awready = !s_d.aw_full;
    s_d.rsp.wready = !s_d.w_full;

    // register read
    if (s_q.rsp.rvalid && axi_i.rready) begin
      s_d.rsp.rvalid = 1'b0;
    end
    if (s_q.rsp.arready && axi_i.arvalid) begin
      off = axi_i.araddr - OFS_CFG;
      if (axi_i.araddr[7:2] == OFS_STATUS[7:2]) begin
        rdv = {14'h0, s_q.role, 1'b0, s_q.addr, 1'b0, s_q.seen, s_q.fail, s_q.ok,
               s_q.st != ST_IDLE, slave, master, s_q.capt};
      end else if (axi_i.araddr[7:2] == OFS_IRQ_STS[7:2]) begin
        rdv = {29'h0, s_q.sts};
        clr = s_q.sts;
      end else if (axi_i.araddr[7:2] == OFS_IRQ_MASK[7:2]) begin
        rdv = {29'h0, s_q.mask};
      end else if (axi_i.araddr[7:2] == OFS_CTRL[7:2]) begin
        rdv = 32'h0;
      end else if (axi_i.araddr >= OFS_CFG && off[7:2] < 6'(N_CFG)) begin
        rdv = {24'h0, s_q.cfg[off[7:2]]};
      end else begin
        rerr = 1'b1;
      end
      s_d.rsp.rvalid = 1'b1;
      s_d.rsp.rdata = rdv;
      s_d.rsp.rresp = rerr ? RESP_SLVERR : RESP_OKAY;
    end
    s_d.rsp.arready = !s_d.rsp.rvalid;

    // bus engine: quarter-bit phases; phase 2 waits for the released clock to read high,
    // so a stretching partner is honoured before sampling, a start or a stop
    stretch = (s_q.st != ST_IDLE) && (s_q.ph == 2'h2) && !p.serial_bus_clock; // [RL13]
    tick = (s_q.qc == 16'h0) && !stretch;
    if (s_q.st != ST_IDLE && !stretch) begin
      s_d.qc = tick ? 16'(QTR - 1) : s_q.qc - 16'h1;
    end
    if (s_q.st != ST_IDLE && tick) begin
      s_d.ph = s_q.ph + 2'h1;
    end
    unique case (s_q.st)
      ST_IDLE: begin
        s_d.pout.serial_bus_clock_oe = 1'b0;
        s_d.pout.sda_oe = 1'b0;
        s_d.qc = 16'(QTR - 1);
        // only a read enable edge, or a go write before a successful load, starts a load: a level held low after done does not
        if (master && (ren_fall || (go && !s_q.ok))) begin // [RL4] [RL6]
          s_d.st = ST_START;
          s_d.ph = 2'h0;
          s_d.step = 8'h0;
          s_d.rd = 1'b0;
          s_d.ok = 1'b0;
          s_d.fail = 1'b0;
          s_d.sh = {EEPROM_DEV, 1'b0};
        end
      end
      ST_START: if (tick) begin
        unique case (s_q.ph)
          2'h0: s_d.pout.sda_oe = 1'b0;
          2'h1: s_d.pout.serial_bus_clock_oe = 1'b0;
          2'h2: s_d.pout.sda_oe = 1'b1;
          2'h3: begin
            s_d.pout.serial_bus_clock_oe = 1'b1; // [RL13]
            s_d.st = ST_BIT;
            s_d.bi = 4'h0;
          end
        endcase
      end
      ST_BIT: if (tick) begin
        unique case (s_q.ph)
          2'h0: begin
            if (s_q.rd) s_d.pout.sda_oe = (s_q.bi == 4'h8) && !s_q.last;
            else s_d.pout.sda_oe = (s_q.bi != 4'h8) && !s_q.sh[7];
          end
          2'h1: s_d.pout.serial_bus_clock_oe = 1'b0; // [RL13]
          2'h2: begin
            if (s_q.bi == 4'h8) s_d.nak = p.sda;
            else if (s_q.rd) s_d.sh = {s_q.sh[6:0], p.sda};
          end
          2'h3: begin
            s_d.pout.serial_bus_clock_oe = 1'b1;
            s_d.bi = s_q.bi + 4'h1;
            if (s_q.bi != 4'h8) begin
              if (!s_q.rd) s_d.sh = {s_q.sh[6:0], 1'b0};
            end else if (!s_q.rd && s_q.nak) begin
              s_d.fail = 1'b1;
              s_d.st = ST_STOP;
            end else if (s_q.rd) begin
              s_d.cfg[ci] = s_q.sh; // [RL14]
              s_d.bi = 4'h0;
              s_d.step = s_q.step + 8'h1;
              s_d.last = (s_q.step - 8'h02) == 8'(N_CFG - 1);
              if (s_q.last) s_d.st = ST_STOP;
            end else begin
              s_d.bi = 4'h0;
              s_d.step = s_q.step + 8'h1;
              if (s_q.step == 8'h0) begin
                s_d.sh = EEPROM_START;
              end else if (s_q.step == 8'h1) begin
                s_d.sh = {EEPROM_DEV, 1'b1}; // [RL14]
                s_d.st = ST_START;
              end else begin
                s_d.rd = 1'b1;
                s_d.last = (N_CFG == 1);
              end
            end
          end
        endcase
      end
      ST_STOP: if (tick) begin
        unique case (s_q.ph)
          2'h0: s_d.pout.sda_oe = 1'b1;
          2'h1: s_d.pout.serial_bus_clock_oe = 1'b0;
          2'h2: s_d.pout.sda_oe = 1'b0;
          2'h3: begin
            s_d.st = ST_IDLE;
            s_d.ok = !s_q.fail; // [RL5]
            ev[IRQ_OK] = !s_q.fail;
            ev[IRQ_FAIL] = s_q.fail;
          end
        endcase
      end
    endcase

    // slave mode: read enable low is a reset of engine and config bytes
    if (slave && ren_low) begin // [RL7] [RL8]
      s_d.st = ST_IDLE;
      s_d.pout.serial_bus_clock_oe = 1'b0;
      s_d.pout.sda_oe = 1'b0;
      s_d.cfg = '0;
      s_d.ok = 1'b0;
      s_d.seen = 1'b1;
      ev[IRQ_SRST] = ren_fall;
    end

    s_d.pout.serial_bus_clock_o = 1'b0;
    s_d.pout.sda_o = 1'b0;
    if (master) begin
      s_d.pout.load_done_n_oe = 1'b1;
      s_d.pout.load_done_n_o = !s_d.ok; // [RL5]
    end else begin
      // chained slaves see this low on their own read enable
      s_d.pout.load_done_n_oe = slave && s_d.seen; // [RL9] [RL10]
      s_d.pout.load_done_n_o = 1'b0;
    end
    // no pull-down modelled: a floating input reaches us as low
    s_d.pout.cal_clk_out = p.cal_clk; // [RL11] [RL12]

    // an event in the clearing read's cycle survives
    s_d.sts = (s_q.sts & ~clr) | ev;
    s_d.irq = |(s_d.sts & s_d.mask);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.ren_q <= 1'b1;
      s_q.mask <= MASK_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign axi_o = s_q.rsp;
  assign pins_o = s_q.pout;
  assign slave_addr = s_q.addr;
  assign irq = s_q.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  strap_capture_a: assert property ($rose(s_q.capt) |-> // [RL1]
    s_q.saddr == $past({p.address_strap_high, p.address_strap_low}))
    else $error("address not taken from straps");
  addr_frozen_a: assert property (s_q.capt |=> $stable(s_q.addr)) // [RL2]
    else $error("address changed after capture");
  role_select_a: assert property (s_q.capt && s_q.role == LVL_F |-> // [RL3]
    ##1 pins_o.load_done_n_oe) else $error("float role not master");
  load_start_a: assert property (master && ren_fall && s_q.st == ST_IDLE // [RL4]
    |=> s_q.st == ST_START ##1 pins_o.load_done_n_o) else $error("load did not start");
  done_high_a: assert property (master && s_q.st != ST_IDLE |-> // [RL5]
    pins_o.load_done_n_oe && pins_o.load_done_n_o) else $error("done low during load");
  no_reload_a: assert property (s_q.ok && ren_low && !ren_fall && s_q.st == ST_IDLE // [RL6]
    |=> s_q.st == ST_IDLE [*2]) else $error("load restarted without new edge");
  slave_hold_a: assert property (slave && ren_low |=> // [RL7]
    s_q.st == ST_IDLE && s_q.cfg == '0) else $error("slave not held in reset");
  slave_tri_a: assert property (slave && !s_q.seen && !ren_low |=> // [RL9]
    !pins_o.load_done_n_oe) else $error("done driven before read enable low");
  slave_chain_a: assert property (slave && ren_low |=> // [RL10]
    pins_o.load_done_n_oe && !pins_o.load_done_n_o) else $error("reset not passed on");
  cal_copy_a: assert property (pins_o.cal_clk_out == $past(p.cal_clk)) // [RL11]
    else $error("calibration clock copy wrong");
  bus_release_a: assert property (s_q.st == ST_IDLE && !$past(s_q.st != ST_IDLE) // [RL13]
    |-> !pins_o.serial_bus_clock_oe && !pins_o.sda_oe) else $error("bus held while idle");

  load_ok_c: cover property ($rose(s_q.ok));
  load_fail_c: cover property ($rose(s_q.fail));
  slave_reset_c: cover property (slave && ren_fall);
endmodule : scb_ctrl
`default_nettype wire

//--- bench/scb_eeprom.sv
`timescale 1ns/1ns
`default_nettype none
module scb_eeprom #(
  parameter logic [6:0] DEV = 7'h50
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic nak,
  input wire logic slow,
  output logic sda_oe,
  output logic scl_oe
);
  logic [7:0] mem [0:255];
  logic [7:0] sh;
  logic [7:0] ptr;
  logic act;
  logic rd;
  logic dev;
  int bc;
  initial begin
    sda_oe = 1'b0;
    scl_oe = 1'b0;
    act = 1'b0;
  end
  always @(negedge sda) if (scl) begin
    act = 1'b1;
    rd = 1'b0;
    dev = 1'b1;
    bc = 0;
  end
  always @(posedge sda) if (scl) begin
    act = 1'b0;
    sda_oe = 1'b0;
  end
  always @(posedge scl) if (act) begin
    if (!rd && bc < 8) sh = {sh[6:0], sda};
    else if (rd && bc == 8 && sda) act = 1'b0; // master nack ends the read
    bc = bc + 1;
  end
  // lines only ever pulled low, never driven high
  always @(negedge scl) if (act) begin
    sda_oe = 1'b0;
    if (bc == 9) bc = 0;
    if (bc == 8 && !rd) begin
      if (dev) begin
        rd = sh[0];
        act = (sh[7:1] == DEV) && !nak;
      end else ptr = sh;
      dev = 1'b0;
      sda_oe = act;
    end else if (rd && bc < 8) begin
      if (bc == 0) begin
        sh = mem[ptr];
        ptr = ptr + 8'h01;
      end
      sda_oe = !sh[7 - bc];
    end
  end
  // slow partner: holds the clock low after each falling edge
  always @(negedge scl) if (slow) begin
    scl_oe = 1'b1;
    #300;
    scl_oe = 1'b0;
  end
endmodule : scb_eeprom
`default_nettype wire

//--- bench/scb_ctrl_test.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    tests_run++; \
    if ((g) !== (e)) begin \
      bad_count++; \
      $display("ERROR %s expected %h seen %h", nm, e, g); \
    end \
  end
module scb_ctrl_test;
  import scb_pkg::*;
  localparam logic [2:0] TOP = 3'h2;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  scb_axi_req_t req = '0;
  scb_axi_rsp_t rsp;
  scb_pout_t po;
  logic [1:0] a_lo = 2'h0;
  logic [1:0] a_hi = 2'h0;
  logic [1:0] role = 2'h2;
  logic ren_n = 1'b1; // pull-up level when nobody drives
  logic cal = 1'b0;
  logic nak = 1'b0;
  logic slow = 1'b0;
  logic e_scl;
  logic e_sda;
  wire logic scl = !(po.serial_bus_clock_oe || e_scl);
  wire logic sda = !(po.sda_oe || e_sda);
  wire scb_pins_t pins = {a_lo, a_hi, role, ren_n, cal, scl, sda};
  logic [6:0] addr;
  logic irq;
  int bad_count = 0;
  int tests_run = 0;
  int cal_n = 0;
  int n0;
  logic [31:0] st = 32'd88;
  logic [31:0] d;
  logic [1:0] r;
  int img[$];

  always #5 clk = !clk;
  always #80 cal = !cal;
  always @(posedge po.cal_clk_out) cal_n++;

  scb_ctrl #(.QTR(4), .ADDR_TOP(TOP)) uut (.clk(clk), .rst_n(rst_n), .axi_i(req),
    .axi_o(rsp), .pins_i(pins), .pins_o(po), .slave_addr(addr), .irq(irq));
  scb_eeprom #(.DEV(EEPROM_DEV)) ee (.scl(scl), .sda(sda), .nak(nak), .slow(slow),
    .sda_oe(e_sda), .scl_oe(e_scl));

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xs

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  task automatic hang;
    bad_count++;
    $display("ERROR wait expected 1 seen 0");
    summarize();
  endtask : hang

  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) break;
    end
    if (n == 50) hang();
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge clk);
    req.awaddr <= a;
    req.wdata <= v;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) break;
    end
    if (n == 50) hang();
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask : wr

  task automatic restart(input logic [1:0] ro, input logic [1:0] lo, input logic [1:0] hi);
    @(posedge clk);
    rst_n <= 1'b0;
    role <= ro;
    a_lo <= lo;
    a_hi <= hi;
    ren_n <= 1'b1;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (12) @(posedge clk);
  endtask : restart

  task automatic wait_load;
    int n;
    repeat (10) @(posedge clk);
    `CHK("done_busy", 1'b1, po.load_done_n_o)
    for (n = 0; n < 3000; n++) begin
      rd(OFS_STATUS);
      if (!d[3]) break;
    end
    if (n == 3000) hang();
  endtask : wait_load

  task automatic chk_cfg(input logic zero);
    for (int i = 0; i < 8; i++) begin
      rd(OFS_CFG + 8'(i * 4));
      `CHK("cfg", zero ? 32'h0 : 32'(img[i]), d)
    end
  endtask : chk_cfg

  initial begin
    for (int i = 0; i < 8; i++) begin
      st = xs(st);
      ee.mem[EEPROM_START + 8'(i)] = st[7:0];
      img.push_back(int'(st[7:0]));
    end
    for (int i = 0; i < 16; i++) begin
      restart(LVL_F, i[1:0], i[3:2]);
      a_lo <= ~i[1:0];
      a_hi <= ~i[3:2];
      repeat (10) @(posedge clk);
      `CHK("slave_addr", {TOP, i[3:2], i[1:0]}, addr)
    end
    restart(LVL_F, LVL_R, LVL_1);
    rd(OFS_STATUS);
    `CHK("status", {14'h0, LVL_F, 1'b0, TOP, LVL_1, LVL_R, 8'h03}, d)
    `CHK("done_idle", 2'b11, {po.load_done_n_o, po.load_done_n_oe})
    rd(OFS_IRQ_MASK);
    `CHK("mask_rst", 32'h0, d)
    rd(8'hFC);
    `CHK("rresp", RESP_SLVERR, r)
    wr(8'hFC, 32'h1);
    `CHK("bresp", RESP_SLVERR, r)
    wr(OFS_IRQ_MASK, 32'h5);
    ren_n <= 1'b0;
    wait_load();
    `CHK("done_ok", 2'b01, {po.load_done_n_o, po.load_done_n_oe})
    chk_cfg(1'b0);
    `CHK("irq_ok", 1'b1, irq)
    rd(OFS_IRQ_STS);
    `CHK("irq_sts", 32'h1, d)
    repeat (3) @(posedge clk);
    `CHK("irq_clr", 1'b0, irq)
    repeat (300) @(posedge clk);
    rd(OFS_STATUS);
    `CHK("no_reload", 2'b10, d[4:3])
    ren_n <= 1'b1;
    repeat (10) @(posedge clk);
    nak <= 1'b1;
    ren_n <= 1'b0;
    wait_load();
    `CHK("done_fail", 2'b11, {po.load_done_n_o, po.load_done_n_oe})
    rd(OFS_STATUS);
    `CHK("fail_st", 3'b100, d[5:3])
    `CHK("irq_masked", 1'b0, irq)
    rd(OFS_IRQ_STS);
    `CHK("irq_fail", 32'h2, d)
    nak <= 1'b0;
    slow <= 1'b1;
    wr(OFS_CTRL, 32'h1);
    wait_load();
    `CHK("done_retry", 1'b0, po.load_done_n_o)
    chk_cfg(1'b0);
    slow <= 1'b0;
    n0 = cal_n;
    repeat (160) @(posedge clk);
    `CHK("cal_out", 1'b1, (cal_n - n0) inside {[9:11]})
    restart(LVL_1, LVL_0, LVL_0);
    `CHK("slv_hiz", 1'b0, po.load_done_n_oe)
    ren_n <= 1'b0;
    repeat (10) @(posedge clk);
    `CHK("slv_low", 2'b01, {po.load_done_n_o, po.load_done_n_oe})
    ren_n <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK("slv_hold", 2'b01, {po.load_done_n_o, po.load_done_n_oe})
    `CHK("slv_no_bus", 1'b0, po.serial_bus_clock_oe)
    wr(OFS_IRQ_MASK, 32'h4);
    `CHK("irq_srst", 1'b1, irq)
    rd(OFS_STATUS);
    `CHK("slv_seen", 1'b1, d[6])
    chk_cfg(1'b1);
    restart(LVL_0, LVL_0, LVL_0);
    ren_n <= 1'b0;
    repeat (40) @(posedge clk);
    `CHK("reserved", 2'b00, {po.load_done_n_oe, po.serial_bus_clock_oe})
    summarize();
  end
endmodule : scb_ctrl_test
`default_nettype wire
